// *** inc/btd_pkg.sv ***
package btd_pkg;

    // Geometry
    localparam int unsigned NUM_SENSORS = 8;
    localparam int unsigned TICK_W      = 16;
    localparam int unsigned REG_W       = 8;
    localparam int unsigned ADDR_W      = 8;

    // Register offsets
    localparam logic [7:0] ADDR_THRESH0      = 8'h13;
    localparam logic [7:0] ADDR_PER_COMP     = 8'h1f;
    localparam logic [7:0] ADDR_EVENT_CFG    = 8'h21;
    localparam logic [7:0] ADDR_AVG_LEVEL    = 8'h22;
    localparam logic [7:0] ADDR_NEG_LEVEL    = 8'h23;
    localparam logic [7:0] ADDR_NEG_COUNT    = 8'h24;
    localparam logic [7:0] ADDR_HYSTERESIS   = 8'h25;
    localparam logic [7:0] ADDR_STUCK        = 8'h26;
    localparam logic [7:0] ADDR_BUTTON_STATE = 8'h27;

    // Reset values
    localparam logic [7:0] RST_THRESH     = 8'h20;
    localparam logic [3:0] RST_PER_COMP   = 4'h0;
    localparam logic [7:0] RST_EVENT_CFG  = 8'h30;
    localparam logic [7:0] RST_AVG_LEVEL  = 8'h50;
    localparam logic [7:0] RST_NEG_LEVEL  = 8'h50;
    localparam logic [7:0] RST_NEG_COUNT  = 8'h01;
    localparam logic [7:0] RST_HYSTERESIS = 8'h0a;
    localparam logic [7:0] RST_STUCK      = 8'h00;

    // Event configuration fields
    localparam int unsigned CFG_REPORT_LSB = 6;
    localparam int unsigned CFG_IRQ_LSB    = 4;
    localparam int unsigned CFG_RDEB_LSB   = 2;
    localparam int unsigned CFG_TDEB_LSB   = 0;
    localparam int unsigned PER_COMP_W     = 4;

    typedef enum logic [1:0] {
        BTD_REPORT_ALL   = 2'b00,
        BTD_REPORT_FIRST = 2'b01
    } btd_report_t;

    localparam logic [1:0] IRQ_TOUCH_BIT   = 2'b01;
    localparam logic [1:0] IRQ_RELEASE_BIT = 2'b10;

    // Scaling
    localparam int unsigned TICK_STEP       = 4;
    localparam int unsigned PCT_FULL        = 100;
    localparam int unsigned AVG_COMP_COUNT  = 3;

    // Time base
    localparam longint unsigned SECOND_NS       = 64'd1_000_000_000;
    localparam longint unsigned CLK_PERIOD_NS   = 64'd4;
    localparam int unsigned     SECOND_CYCLES   = int'(SECOND_NS / CLK_PERIOD_NS);
    localparam int unsigned     PRESCALE_W      = 28;

    // Periodic compensation interval in seconds per code
    function automatic logic [5:0] per_comp_seconds(input logic [3:0] code);
        logic [5:0] s;
        s = 6'h00;
        if (code == 4'hf) begin
            s = 6'h3c;
        end else if (code >= 4'h8) begin
            s = 6'({code, 1'b0});
        end else begin
            s = 6'(code);
        end
        return s;
    endfunction

endpackage

// *** hw/btd_sensor.sv ***
`timescale 1ns/1ps

// One sense input: thresholds, hysteresis, debounce, stuck timeout, comp triggers
module btd_sensor (
    // Clock and reset
    input  wire logic                             clk_i,
    input  wire logic                             nrst_i,
    // Sample stream
    input  wire logic                             sample_i,
    input  wire logic                             second_i,
    input  wire logic signed [btd_pkg::TICK_W-1:0] ticks_i,
    // Configuration
    input  wire logic [7:0]                       thresh_i,
    input  wire logic [7:0]                       hyst_i,
    input  wire logic [1:0]                       touch_deb_i,
    input  wire logic [1:0]                       rel_deb_i,
    input  wire logic [7:0]                       avg_level_i,
    input  wire logic [7:0]                       neg_level_i,
    input  wire logic [7:0]                       neg_count_i,
    input  wire logic [7:0]                       stuck_i,
    // Results
    output logic                                  touched_o,
    output logic                                  touch_o,
    output logic                                  release_o,
    output logic                                  avg_over_o,
    output logic                                  neg_trig_o,
    output logic                                  stuck_trig_o
);

    typedef struct packed {
        logic       touched;
        logic       stuck;
        logic [2:0] deb;
        logic [7:0] neg_cnt;
        logic [7:0] secs;
        logic       touch_ev;
        logic       release_ev;
        logic       avg_over;
        logic       neg_trig;
        logic       stuck_trig;
    } btd_sensor_t;

    btd_sensor_t st;
    btd_sensor_t next_st;

    logic        [9:0]  thr_ticks;
    logic        [17:0] hyst_prod;
    logic        [11:0] hyst_amt;
    logic signed [16:0] tk;
    logic signed [16:0] touch_lvl;
    logic signed [16:0] rel_lvl;
    logic signed [16:0] neg_lvl;
    logic signed [16:0] avg_lvl;
    logic        [7:0]  neg_limit;

    always_comb begin
        thr_ticks = 10'(thresh_i * btd_pkg::TICK_STEP);
        hyst_prod = 18'(thr_ticks * hyst_i);
        hyst_amt  = 12'(hyst_prod / 18'(btd_pkg::PCT_FULL));
        tk        = 17'(ticks_i);
        touch_lvl = $signed(17'(thr_ticks)) + $signed(17'(hyst_amt));
        rel_lvl   = $signed(17'(thr_ticks)) - $signed(17'(hyst_amt));
        neg_lvl   = 17'sd0 - $signed(17'(neg_level_i * btd_pkg::TICK_STEP));
        avg_lvl   = $signed(17'(avg_level_i * btd_pkg::TICK_STEP));
        neg_limit = (neg_count_i == 8'h00) ? 8'h01 : neg_count_i;
    end

    always_comb begin
        next_st            = st;
        next_st.touch_ev   = 1'b0;
        next_st.release_ev = 1'b0;
        next_st.neg_trig   = 1'b0;
        next_st.stuck_trig = 1'b0;
        // Stuck-touch timer counts whole seconds while touched
        if (st.touched && second_i && stuck_i != 8'h00) begin
            if (st.secs + 8'h01 >= stuck_i) begin
                next_st.touched    = 1'b0;
                next_st.stuck      = 1'b1;
                next_st.release_ev = 1'b1;
                next_st.stuck_trig = 1'b1;
                next_st.secs       = 8'h00;
                next_st.deb        = 3'h0;
            end else begin
                next_st.secs = st.secs + 8'h01;
            end
        end
        // Threshold decisions advance only on the scan boundary; the stuck timeout above runs on seconds
        if (sample_i) begin
            next_st.avg_over = tk > avg_lvl;
            if (tk < neg_lvl) begin
                if (st.neg_cnt + 8'h01 >= neg_limit) begin
                    next_st.neg_trig = 1'b1;
                    next_st.neg_cnt  = 8'h00;
                end else begin
                    next_st.neg_cnt = st.neg_cnt + 8'h01;
                end
            end else begin
                next_st.neg_cnt = 8'h00;
            end
            if (st.stuck) begin
                // A stuck button waits for the finger to lift before it may retrigger
                if (tk < rel_lvl) begin
                    next_st.stuck = 1'b0;
                end
            end else if (!st.touched) begin
                if (tk > touch_lvl) begin
                    if (st.deb >= 3'(touch_deb_i)) begin
                        next_st.touched  = 1'b1;
                        next_st.touch_ev = 1'b1;
                        next_st.deb      = 3'h0;
                        next_st.secs     = 8'h00;
                    end else begin
                        next_st.deb = st.deb + 3'h1;
                    end
                end else begin
                    next_st.deb = 3'h0;
                end
            end else if (next_st.touched) begin
                if (tk < rel_lvl) begin
                    if (st.deb >= 3'(rel_deb_i)) begin
                        next_st.touched    = 1'b0;
                        next_st.release_ev = 1'b1;
                        next_st.deb        = 3'h0;
                    end else begin
                        next_st.deb = st.deb + 3'h1;
                    end
                end else begin
                    next_st.deb = 3'h0;
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign touched_o    = st.touched;
    assign touch_o      = st.touch_ev;
    assign release_o    = st.release_ev;
    assign avg_over_o   = st.avg_over;
    assign neg_trig_o   = st.neg_trig;
    assign stuck_trig_o = st.stuck_trig;

endmodule

// *** hw/btd_decision.sv ***
`timescale 1ns/1ps

module btd_decision #(
    parameter int unsigned NUM_SENSORS   = btd_pkg::NUM_SENSORS,
    parameter int unsigned SECOND_CYCLES = btd_pkg::SECOND_CYCLES
) (
    // Clock and reset
    input  wire logic                                          clk_i,
    input  wire logic                                          nrst_i,
    // Register port
    input  wire logic [btd_pkg::ADDR_W-1:0]                    reg_addr_i,
    input  wire logic                                          reg_wr_i,
    input  wire logic [btd_pkg::REG_W-1:0]                     reg_wdata_i,
    output logic      [btd_pkg::REG_W-1:0]                     reg_rdata_o,
    // Tick samples, one strobe per scan period
    input  wire logic                                          sample_i,
    input  wire logic [NUM_SENSORS*btd_pkg::TICK_W-1:0]        ticks_i,
    // Reporting
    output logic      [NUM_SENSORS-1:0]                        button_state_o,
    output logic      [NUM_SENSORS-1:0]                        touch_event_o,
    output logic      [NUM_SENSORS-1:0]                        release_event_o,
    output logic                                               irq_o,
    // Front-end control
    output logic      [NUM_SENSORS-1:0]                        avg_suspend_o,
    output logic                                               comp_request_o
);

    typedef struct packed {
        logic [NUM_SENSORS-1:0][7:0]           thresh;
        logic [btd_pkg::PER_COMP_W-1:0]        per_comp;
        logic [7:0]                            event_cfg;
        logic [7:0]                            avg_level;
        logic [7:0]                            neg_level;
        logic [7:0]                            neg_count;
        logic [7:0]                            hyst;
        logic [7:0]                            stuck;
        logic [7:0]                            rdata;
        logic [btd_pkg::PRESCALE_W-1:0]        prescale;
        logic                                  second;
        logic [5:0]                            per_secs;
        logic                                  owner_v;
        logic [$clog2(NUM_SENSORS)-1:0]        owner;
        logic [NUM_SENSORS-1:0]                state;
        logic [NUM_SENSORS-1:0]                touch_ev;
        logic [NUM_SENSORS-1:0]                release_ev;
        logic                                  irq;
        logic [NUM_SENSORS-1:0]                avg_sus;
        logic                                  comp;
    } btd_state_t;

    btd_state_t st;
    btd_state_t next_st;

    logic [NUM_SENSORS-1:0] s_touched;
    logic [NUM_SENSORS-1:0] s_touch;
    logic [NUM_SENSORS-1:0] s_release;
    logic [NUM_SENSORS-1:0] s_avg;
    logic [NUM_SENSORS-1:0] s_neg;
    logic [NUM_SENSORS-1:0] s_stuck;
    logic                   sample_d;

    // Proximity inputs take the same path as touch buttons
    for (genvar g = 0; g < NUM_SENSORS; g++) begin : g_sensor
        btd_sensor u_sensor (
            .clk_i       (clk_i),
            .nrst_i      (nrst_i),
            .sample_i    (sample_i),
            .second_i    (st.second),
            .ticks_i     (ticks_i[g*btd_pkg::TICK_W +: btd_pkg::TICK_W]),
            .thresh_i    (st.thresh[g]),
            .hyst_i      (st.hyst),
            .touch_deb_i (st.event_cfg[btd_pkg::CFG_TDEB_LSB +: 2]),
            .rel_deb_i   (st.event_cfg[btd_pkg::CFG_RDEB_LSB +: 2]),
            .avg_level_i (st.avg_level),
            .neg_level_i (st.neg_level),
            .neg_count_i (st.neg_count),
            .stuck_i     (st.stuck),
            .touched_o   (s_touched[g]),
            .touch_o     (s_touch[g]),
            .release_o   (s_release[g]),
            .avg_over_o  (s_avg[g]),
            .neg_trig_o  (s_neg[g]),
            .stuck_trig_o(s_stuck[g])
        );
    end

    // Sensor results settle one cycle after the scan strobe
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sample_d <= 1'b0;
        end else begin
            sample_d <= sample_i;
        end
    end

    always_comb begin
        logic [1:0]                     rmode;
        logic [1:0]                     imask;
        logic [3:0]                     avg_cnt;
        logic                           found;
        logic [NUM_SENSORS-1:0]         rep_t;
        logic [NUM_SENSORS-1:0]         rep_r;
        logic [7:0]                     rd;
        rmode   = st.event_cfg[btd_pkg::CFG_REPORT_LSB +: 2];
        imask   = st.event_cfg[btd_pkg::CFG_IRQ_LSB +: 2];
        avg_cnt = 4'h0;
        found   = 1'b0;
        rep_t   = '0;
        rep_r   = '0;
        rd      = 8'h00;
        next_st = st;
        next_st.touch_ev   = '0;
        next_st.release_ev = '0;
        next_st.irq        = 1'b0;
        next_st.comp       = 1'b0;
        next_st.second     = 1'b0;

        // Register writes
        if (reg_wr_i) begin
            for (int i = 0; i < NUM_SENSORS; i++) begin
                if (reg_addr_i == btd_pkg::ADDR_THRESH0 + 8'(i)) begin
                    next_st.thresh[i] = reg_wdata_i;
                end
            end
            unique case (reg_addr_i)
                btd_pkg::ADDR_PER_COMP:   next_st.per_comp  = reg_wdata_i[btd_pkg::PER_COMP_W-1:0];
                btd_pkg::ADDR_EVENT_CFG:  next_st.event_cfg = reg_wdata_i;
                btd_pkg::ADDR_AVG_LEVEL:  next_st.avg_level = reg_wdata_i;
                btd_pkg::ADDR_NEG_LEVEL:  next_st.neg_level = reg_wdata_i;
                btd_pkg::ADDR_NEG_COUNT:  next_st.neg_count = reg_wdata_i;
                btd_pkg::ADDR_HYSTERESIS: next_st.hyst      = reg_wdata_i;
                btd_pkg::ADDR_STUCK:      next_st.stuck     = reg_wdata_i;
                default: ;
            endcase
        end

        // Register read data follows the address
        for (int i = 0; i < NUM_SENSORS; i++) begin
            if (reg_addr_i == btd_pkg::ADDR_THRESH0 + 8'(i)) begin
                rd = st.thresh[i];
            end
        end
        unique case (reg_addr_i)
            btd_pkg::ADDR_PER_COMP:     rd = 8'(st.per_comp);
            btd_pkg::ADDR_EVENT_CFG:    rd = st.event_cfg;
            btd_pkg::ADDR_AVG_LEVEL:    rd = st.avg_level;
            btd_pkg::ADDR_NEG_LEVEL:    rd = st.neg_level;
            btd_pkg::ADDR_NEG_COUNT:    rd = st.neg_count;
            btd_pkg::ADDR_HYSTERESIS:   rd = st.hyst;
            btd_pkg::ADDR_STUCK:        rd = st.stuck;
            btd_pkg::ADDR_BUTTON_STATE: rd = 8'(st.state);
            default: ;
        endcase
        next_st.rdata = rd;

        // One-second time base
        if (st.prescale == btd_pkg::PRESCALE_W'(SECOND_CYCLES - 1)) begin
            next_st.prescale = '0;
            next_st.second   = 1'b1;
        end else begin
            next_st.prescale = st.prescale + 1'b1;
        end

        // Periodic compensation while every button rests released
        if (st.per_comp == '0 || s_touched != '0) begin
            next_st.per_secs = 6'h00;
        end else if (st.second) begin
            if (st.per_secs + 6'h01 >= btd_pkg::per_comp_seconds(st.per_comp)) begin
                next_st.per_secs = 6'h00;
                next_st.comp     = 1'b1;
            end else begin
                next_st.per_secs = st.per_secs + 6'h01;
            end
        end

        // Reporting on the settled scan results
        if (sample_d) begin
            next_st.avg_sus = s_avg;
            for (int i = 0; i < NUM_SENSORS; i++) begin
                avg_cnt = avg_cnt + 4'(s_avg[i]);
            end
            if (avg_cnt >= 4'(btd_pkg::AVG_COMP_COUNT)) begin
                next_st.comp = 1'b1;
            end
        end
        if (s_neg != '0 || s_stuck != '0) begin
            next_st.comp = 1'b1;
        end

        if (rmode == btd_pkg::BTD_REPORT_FIRST) begin
            if (st.owner_v) begin
                if (s_release[st.owner]) begin
                    rep_r[st.owner] = 1'b1;
                    next_st.owner_v = 1'b0;
                end
            end else begin
                for (int i = 0; i < NUM_SENSORS; i++) begin
                    if (s_touch[i] && !found) begin
                        found           = 1'b1;
                        rep_t[i]        = 1'b1;
                        next_st.owner_v = 1'b1;
                        next_st.owner   = ($clog2(NUM_SENSORS))'(i);
                    end
                end
            end
            next_st.state = '0;
            if (next_st.owner_v) begin
                next_st.state[next_st.owner] = 1'b1;
            end
        end else begin
            // Reserved codes behave as report-all
            rep_t           = s_touch;
            rep_r           = s_release;
            next_st.owner_v = 1'b0;
            next_st.state   = (st.state | s_touch) & ~s_release;
        end
        next_st.touch_ev   = rep_t;
        next_st.release_ev = rep_r;
        next_st.irq        = ((rep_t != '0) && imask[0] == btd_pkg::IRQ_TOUCH_BIT[0])
                           || ((rep_r != '0) && imask[1] == btd_pkg::IRQ_RELEASE_BIT[1]);
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st           <= '0;
            st.thresh    <= {NUM_SENSORS{btd_pkg::RST_THRESH}};
            st.per_comp  <= btd_pkg::RST_PER_COMP;
            st.event_cfg <= btd_pkg::RST_EVENT_CFG;
            st.avg_level <= btd_pkg::RST_AVG_LEVEL;
            st.neg_level <= btd_pkg::RST_NEG_LEVEL;
            st.neg_count <= btd_pkg::RST_NEG_COUNT;
            st.hyst      <= btd_pkg::RST_HYSTERESIS;
            st.stuck     <= btd_pkg::RST_STUCK;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata_o     = st.rdata;
    assign button_state_o  = st.state;
    assign touch_event_o   = st.touch_ev;
    assign release_event_o = st.release_ev;
    assign irq_o           = st.irq;
    assign avg_suspend_o   = st.avg_sus;
    assign comp_request_o  = st.comp;

endmodule

// *** test/btd_front_end_model.sv ***
`timescale 1ns/1ps

// Front end: one tick set per scan request, lines scrambled between scans
module btd_front_end_model (
    // Clock and request
    input  wire logic         clk_i,
    input  wire logic         scan_i,
    input  wire logic [127:0] level_i,
    // Toward the decision block
    output logic              sample_o = 1'b0,
    output logic      [127:0] ticks_o = '0
);
    logic pend = 1'b0;

    always @(posedge clk_i) begin
        pend <= scan_i;
    end

    // Ticks hold only with the strobe; afterwards the lines change
    always @(negedge clk_i) begin
        sample_o <= pend;
        ticks_o  <= pend ? level_i : ~ticks_o;
    end
endmodule

// *** test/btd_decision_sva.sv ***
`timescale 1ns/1ps

module btd_decision_sva #(
    parameter int unsigned NUM_SENSORS = 8
) (
    // Clock and reset
    input wire logic                        clk_i,
    input wire logic                        nrst_i,
    // Samples
    input wire logic                        sample_i,
    input wire logic [NUM_SENSORS*16-1:0]   ticks_i,
    // Results
    input wire logic [NUM_SENSORS-1:0]      button_state_o,
    input wire logic [NUM_SENSORS-1:0]      touch_event_o,
    input wire logic [NUM_SENSORS-1:0]      release_event_o,
    input wire logic                        irq_o,
    input wire logic [NUM_SENSORS-1:0]      avg_suspend_o,
    input wire logic                        comp_request_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    // A stuck-touch release comes with its compensation request, off the scan grid
    a_event_latency: assert property ((touch_event_o | release_event_o) != '0
        |-> $past(sample_i, 2) || comp_request_o) else $error("event without scan");
    a_irq_cause: assert property (irq_o |-> (touch_event_o | release_event_o) != '0) else $error("irq without event");
    a_touch_state: assert property ((button_state_o & ~$past(button_state_o)) == touch_event_o) else $error("state rise mismatch");
    a_release_state: assert property (release_event_o != '0 |-> (release_event_o & (button_state_o | ~$past(button_state_o))) == '0) else $error("release without fall");
    a_event_pulse: assert property (touch_event_o != '0 |=> touch_event_o == '0) else $error("touch event too long");
    a_avg_comp: assert property ($past(sample_i, 2) && $countones(avg_suspend_o) >= 3 |-> comp_request_o) else $error("no comp on three");
    a_avg_timing: assert property ($changed(avg_suspend_o) |-> $past(sample_i, 2)) else $error("suspend off scan");
    a_touch_ticks: assert property (touch_event_o[0] |-> $signed($past(ticks_i[15:0], 2)) > 16'sh0000) else $error("touch on low ticks");
endmodule

bind btd_decision btd_decision_sva #(.NUM_SENSORS(NUM_SENSORS)) u_sva (.clk_i, .nrst_i, .sample_i, .ticks_i,
    .button_state_o, .touch_event_o, .release_event_o, .irq_o, .avg_suspend_o, .comp_request_o);

// *** test/testbench.sv ***
`timescale 1ns/1ps

module testbench;
    logic         clk_i = 1'b0;
    logic         nrst_i = 1'b0;
    logic [7:0]   reg_addr_i = 8'h00;
    logic         reg_wr_i = 1'b0;
    logic [7:0]   reg_wdata_i = 8'h00;
    logic [7:0]   reg_rdata_o, button_state_o, touch_event_o, release_event_o, avg_suspend_o;
    logic         sample_i, irq_o, comp_request_o;
    logic [127:0] ticks_i;
    logic         scan = 1'b0;
    logic [127:0] level = '0;
    int           error_cnt = 0;
    int           checks_done = 0;
    logic [7:0]   rv [6] = '{8'h30, 8'h50, 8'h50, 8'h01, 8'h0a, 8'h00};

    always #2 clk_i = ~clk_i;

    btd_decision #(.SECOND_CYCLES(20)) uut (.clk_i, .nrst_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rdata_o,
        .sample_i, .ticks_i, .button_state_o, .touch_event_o, .release_event_o, .irq_o, .avg_suspend_o, .comp_request_o);
    btd_front_end_model fe (.clk_i, .scan_i(scan), .level_i(level), .sample_o(sample_i), .ticks_o(ticks_i));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t %s got %h want %h", $time, what, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge clk_i);
        reg_wr_i = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_i);
        reg_addr_i = a;
        @(negedge clk_i);
        check(reg_rdata_o, e, "read");
    endtask

    // Same tick value on every sensor of the mask, zero elsewhere
    function automatic logic [127:0] tk(input logic [15:0] v, input logic [7:0] m);
        for (int n = 0; n < 8; n++) begin
            tk[16*n +: 16] = m[n] ? v : 16'h0000;
        end
    endfunction

    // Outputs land two edges after the strobe is taken
    task automatic sc(input logic [127:0] t, input logic [7:0] et, input logic [7:0] er, input logic [1:0] ic);
        @(negedge clk_i);
        level = t;
        scan = 1'b1;
        @(negedge clk_i);
        scan = 1'b0;
        repeat (2) @(negedge clk_i);
        check(touch_event_o, et, "touch");
        check(release_event_o, er, "release");
        check({6'h00, irq_o, comp_request_o}, {6'h00, ic}, "irq comp");
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk_i);
        error_cnt++;
        give_verdict();
    end

    initial begin
        int w;
        int c;
        repeat (12) @(posedge clk_i);
        @(negedge clk_i);
        nrst_i = 1'b1;
        for (int i = 0; i < 6; i++) begin
            rd(8'h21 + 8'(i), rv[i]);
        end
        rd(8'h40, 8'h00);
        wr(8'h14, 8'h40);
        rd(8'h14, 8'h40);
        sc(tk(16'h00c8, 8'h03), 8'h01, 8'h00, 2'b10);
        sc(tk(16'h0078, 8'h01), 8'h00, 8'h00, 2'b00);
        sc(tk(16'h0073, 8'h01), 8'h00, 8'h01, 2'b10);
        wr(8'h21, 8'h35);
        sc(tk(16'h00c8, 8'h01), 8'h00, 8'h00, 2'b00);
        sc(tk(16'h00c8, 8'h01), 8'h01, 8'h00, 2'b10);
        sc(tk(16'h0000, 8'h00), 8'h00, 8'h00, 2'b00);
        sc(tk(16'h0000, 8'h00), 8'h00, 8'h01, 2'b10);
        wr(8'h21, 8'h70);
        sc(tk(16'h00c8, 8'h04), 8'h04, 8'h00, 2'b10);
        sc(tk(16'h00c8, 8'h0c), 8'h00, 8'h00, 2'b00);
        sc(tk(16'h00c8, 8'h04), 8'h00, 8'h00, 2'b00);
        sc(tk(16'h0000, 8'h00), 8'h00, 8'h04, 2'b10);
        for (int m = 0; m < 4; m++) begin
            wr(8'h21, {2'b00, 2'(m), 4'h0});
            sc(tk(16'h00c8, 8'h01), 8'h01, 8'h00, {m[0], 1'b0});
            sc(tk(16'h0000, 8'h00), 8'h00, 8'h01, {m[1], 1'b0});
        end
        wr(8'h21, 8'h30);
        sc(tk(16'h0141, 8'h07), 8'h07, 8'h00, 2'b11);
        check(avg_suspend_o, 8'h07, "avg");
        sc(tk(16'h0140, 8'h07), 8'h00, 8'h00, 2'b00);
        check(avg_suspend_o, 8'h00, "avg");
        sc(tk(16'h0000, 8'h00), 8'h00, 8'h07, 2'b10);
        sc(tk(16'hfebf, 8'h01), 8'h00, 8'h00, 2'b01);
        sc(tk(16'hfec0, 8'h01), 8'h00, 8'h00, 2'b00);
        wr(8'h24, 8'h02);
        sc(tk(16'hfebf, 8'h01), 8'h00, 8'h00, 2'b00);
        sc(tk(16'hfebf, 8'h01), 8'h00, 8'h00, 2'b01);
        // Periodic compensation: held off while touched, runs once released
        sc(tk(16'h00c8, 8'h01), 8'h01, 8'h00, 2'b10);
        wr(8'h1f, 8'hf1);
        rd(8'h1f, 8'h01);
        c = 0;
        repeat (60) begin
            @(negedge clk_i);
            if (comp_request_o === 1'b1) begin
                c++;
            end
        end
        check(8'(c), 8'h00, "held comp");
        wr(8'h1f, 8'h00);
        sc(tk(16'h0000, 8'h00), 8'h00, 8'h01, 2'b10);
        wr(8'h1f, 8'h01);
        w = 0;
        while (comp_request_o !== 1'b1 && w < 60) begin
            @(negedge clk_i);
            w++;
        end
        check({7'h00, comp_request_o}, 8'h01, "periodic comp");
        wr(8'h1f, 8'h00);
        wr(8'h26, 8'h01);
        sc(tk(16'h00c8, 8'h01), 8'h01, 8'h00, 2'b10);
        w = 0;
        while (release_event_o[0] !== 1'b1 && w < 60) begin
            @(negedge clk_i);
            w++;
        end
        check({7'h00, comp_request_o}, 8'h01, "stuck comp");
        check(button_state_o, 8'h00, "stuck state");
        sc(tk(16'h00c8, 8'h01), 8'h00, 8'h00, 2'b00);
        sc(tk(16'h0000, 8'h00), 8'h00, 8'h00, 2'b00);
        sc(tk(16'h00c8, 8'h01), 8'h01, 8'h00, 2'b10);
        give_verdict();
    end
endmodule
